// [logic/nand_access_timing.sv]
// Programmable asynchronous access timer for an 8-bit flash, APB slave
//
// Operation
// - Separate read and write timing fields kept
// - Operation goes command, address, then data
// - Command and address phases are write cycles
// - Data phase writes to program, reads to read
// - Field value N gives N+1 cycles
// - Turnaround between read and following write
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`include "nand_timing_regs.svh"
module nand_access_timing
    import nand_timing_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Flash pins
    output flash_pins_t      pins,
    input  wire logic [7:0]  flash_din
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    timing_cfg_t  cfg_r;          // Timing fields
    seq_state_t   st_r;           // Sequencer state
    seq_state_t   st_nxt;         // Next state
    phase_kind_t  kind_r;         // Kind of running access
    phase_kind_t  kind_nxt;       // Kind seen by next-state logic
    logic [7:0]   wdata_r;        // Byte to drive on writes
    logic [7:0]   rdata_r;        // Last byte read
    logic         last_rd_r;      // Previous access was a read
    logic [31:0]  prdata_r;       // Read data held for access phase
    logic [7:0]   din_s;          // Synchronised data inputs
    logic         tmr_load;       // Start a new phase
    logic [5:0]   tmr_val;        // Length of new phase minus one
    logic         tmr_zero;       // Current phase ends this cycle
    flash_pins_t  pins_r;         // Registered pin drive
    logic [5:0]   strobe_cnt_r;   // Helper: cycles spent in strobe

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    wire         sel_cfg  = (paddr == `CFG_OFS);
    wire         sel_acc  = (paddr == `ACC_OFS);
    wire         sel_stat = (paddr == `STAT_OFS);
    wire         hit      = sel_cfg | sel_acc | sel_stat;
    wire         busy     = (st_r != ST_IDLE);
    // A new access waits in the access phase until the sequencer is idle
    wire         acc_hold = sel_acc & pwrite & busy;
    wire         xfer     = psel & penable & pready;
    wire         wr_cfg   = xfer & pwrite & sel_cfg;
    wire         start    = xfer & pwrite & sel_acc;
    wire [1:0]   kind_in  = pwdata[`ACC_KIND_LSB +: 2];

    assign pready  = ~(psel & penable & acc_hold);
    assign pslverr = psel & penable & ~hit;
    assign prdata  = prdata_r;

    // Read mux; unmapped addresses read zero
    wire [31:0] rd_mux =
        sel_cfg  ? {4'h0, cfg_r} :
        sel_stat ? {16'h0000, rdata_r, 6'h00, last_rd_r, busy} :
                   32'h0000_0000;

    // Read data is latched in the setup cycle, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata_r <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    // Read and write widths live in separate fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= timing_cfg_t'(`CFG_RST);
        end else if (wr_cfg) begin
            cfg_r <= timing_cfg_t'(pwdata[`CFG_BITS-1:0]);
        end
    end

    // Latch each single access request; one phase per write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kind_r  <= PH_CMD;
            wdata_r <= 8'h00;
        end else if (start) begin
            kind_r  <= phase_kind_t'(kind_in);
            wdata_r <= pwdata[`ACC_DATA_LSB +: 8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase lengths

    assign kind_nxt = start ? phase_kind_t'(kind_in) : kind_r;
    wire is_rd = (kind_nxt == PH_RDATA);

    // Read fields for reads, write fields for everything else
    wire [5:0] setup_n  = is_rd ? 6'(cfg_r.r_setup)  : 6'(cfg_r.w_setup);
    wire [5:0] strobe_n = is_rd ? cfg_r.r_strobe     : cfg_r.w_strobe;
    wire [5:0] hold_n   = is_rd ? 6'(cfg_r.r_hold)   : 6'(cfg_r.w_hold);
    wire [5:0] ta_n     = 6'(cfg_r.ta);

    // Timer holds N then counts to zero: N+1 cycles per phase
    phase_timer #(
        .W        (`TMR_W)
    ) phase_timer_inst (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (tmr_load),
        .load_val (tmr_val),
        .zero     (tmr_zero)
    );

    // Data inputs come from the pins and are synchronised first
    bus_sync #(
        .W        (8)
    ) bus_sync_inst (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (flash_din),
        .sync_out (din_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    // Next state and timer load; phases run in fixed order
    always_comb begin
        st_nxt   = st_r;
        tmr_load = 1'b0;
        tmr_val  = `TMR_ZERO;
        unique case (st_r)
            ST_IDLE: begin
                if (start && !is_rd && last_rd_r) begin
                    // Write after read: let the flash release the bus
                    st_nxt   = ST_TURN;
                    tmr_load = 1'b1;
                    tmr_val  = ta_n;
                end else if (start) begin
                    st_nxt   = ST_SETUP;
                    tmr_load = 1'b1;
                    tmr_val  = setup_n;
                end
            end
            ST_TURN: begin
                if (tmr_zero) begin
                    st_nxt   = ST_SETUP;
                    tmr_load = 1'b1;
                    tmr_val  = setup_n;
                end
            end
            ST_SETUP: begin
                if (tmr_zero) begin
                    st_nxt   = ST_STROBE;
                    tmr_load = 1'b1;
                    tmr_val  = strobe_n;
                end
            end
            ST_STROBE: begin
                if (tmr_zero) begin
                    st_nxt   = ST_HOLD;
                    tmr_load = 1'b1;
                    tmr_val  = hold_n;
                end
            end
            ST_HOLD: begin
                if (tmr_zero) begin
                    st_nxt = ST_IDLE;
                end
            end
            default: begin
                // Illegal code: return to idle
                st_nxt = ST_IDLE;
            end
        endcase
    end

    // Pin drive for a given state: select over the whole access, strobe
    // only in its phase, data driven only by writes
    function automatic flash_pins_t drive(seq_state_t s, phase_kind_t k,
                                          logic [7:0] d);
        flash_pins_t p;
        logic        act;
        act    = (s == ST_SETUP) || (s == ST_STROBE) || (s == ST_HOLD);
        p.cs_n = ~act;
        p.we_n = ~((s == ST_STROBE) && (k != PH_RDATA));
        p.oe_n = ~((s == ST_STROBE) && (k == PH_RDATA));
        p.cle  = act && (k == PH_CMD);
        p.ale  = act && (k == PH_ADDR);
        p.doe  = act && (k != PH_RDATA);
        p.dout = d;
        return p;
    endfunction

    wire [7:0] wdata_nxt = start ? pwdata[`ACC_DATA_LSB +: 8] : wdata_r;

    // State, pins and turnaround memory
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r      <= ST_IDLE;
            pins_r    <= drive(ST_IDLE, PH_CMD, 8'h00);
            last_rd_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            pins_r <= drive(st_nxt, kind_nxt, wdata_nxt);
            if (st_r == ST_HOLD && tmr_zero) begin
                last_rd_r <= (kind_r == PH_RDATA);
            end
        end
    end

    // Sample read data in the last strobe cycle. The synchroniser adds two
    // cycles, so the read strobe must cover access time plus two cycles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 8'h00;
        end else if (st_r == ST_STROBE && tmr_zero && kind_r == PH_RDATA) begin
            rdata_r <= din_s;
        end
    end

    assign pins = pins_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Helper: count cycles spent in strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_cnt_r <= `TMR_ZERO;
        end else if (st_r == ST_STROBE) begin
            strobe_cnt_r <= strobe_cnt_r + 6'h01;
        end else begin
            strobe_cnt_r <= `TMR_ZERO;
        end
    end

    property p_cfg_split;
        @(posedge pclk) disable iff (!presetn)
        wr_cfg |=> (cfg_r.r_strobe == $past(pwdata[22:17])) &&
                   (cfg_r.w_strobe == $past(pwdata[9:4]));
    endproperty
    a_cfg_split: assert property (p_cfg_split)
        else $error("timing fields not stored separately");

    property p_latch_excl;
        @(posedge pclk) disable iff (!presetn)
        !(pins.cle && pins.ale);
    endproperty
    a_latch_excl: assert property (p_latch_excl)
        else $error("command and address latch both high");

    property p_cmd_is_write;
        @(posedge pclk) disable iff (!presetn)
        (st_r == ST_STROBE && kind_r != PH_RDATA) |->
            (!pins.we_n && pins.oe_n && pins.doe);
    endproperty
    a_cmd_is_write: assert property (p_cmd_is_write)
        else $error("write access without write strobe");

    property p_read_strobe;
        @(posedge pclk) disable iff (!presetn)
        (st_r == ST_STROBE && kind_r == PH_RDATA) |->
            (!pins.oe_n && pins.we_n && !pins.doe);
    endproperty
    a_read_strobe: assert property (p_read_strobe)
        else $error("read access drives bus or lacks read strobe");

    property p_strobe_len;
        @(posedge pclk) disable iff (!presetn)
        (st_r == ST_STROBE && st_nxt == ST_HOLD) |-> (strobe_cnt_r == strobe_n);
    endproperty
    a_strobe_len: assert property (p_strobe_len)
        else $error("strobe phase not N+1 cycles");

    property p_setup_zero;
        @(posedge pclk) disable iff (!presetn)
        ($rose(st_r == ST_SETUP) && setup_n == 6'h00) |=> (st_r == ST_STROBE);
    endproperty
    a_setup_zero: assert property (p_setup_zero)
        else $error("setup of zero not one cycle");

    property p_turn;
        @(posedge pclk) disable iff (!presetn)
        (st_r == ST_IDLE && start && last_rd_r && !is_rd) |=>
            (st_r == ST_TURN && !pins.doe) [*1] ##0 (pins.cs_n);
    endproperty
    a_turn: assert property (p_turn)
        else $error("write after read skipped turnaround");

    property p_cs_active;
        @(posedge pclk) disable iff (!presetn)
        (st_r == ST_SETUP || st_r == ST_STROBE || st_r == ST_HOLD) |-> !pins.cs_n;
    endproperty
    a_cs_active: assert property (p_cs_active)
        else $error("chip select inactive during access");

    property p_order;
        @(posedge pclk) disable iff (!presetn)
        (st_r == ST_STROBE) ##1 (st_r != ST_STROBE) |-> (st_r == ST_HOLD);
    endproperty
    a_order: assert property (p_order)
        else $error("strobe not followed by hold");

endmodule

// [logic/nand_timing_regs.svh]
// Register offsets, field positions and reset values of the flash access timer
`ifndef NAND_TIMING_REGS_SVH
`define NAND_TIMING_REGS_SVH

// Register byte offsets
`define CFG_OFS        12'h000
`define ACC_OFS        12'h004
`define STAT_OFS       12'h008

// Timing configuration word
`define CFG_BITS       28
`define CFG_RST        28'hFFFFFFF

// Access request word
`define ACC_DATA_LSB   0
`define ACC_KIND_LSB   8

// Status word
`define STAT_BUSY_BIT  0
`define STAT_TURN_BIT  1
`define STAT_RD_LSB    8

// Counter widths and idle values
`define TMR_W          6
`define TMR_ZERO       6'h00
`define ACC_ZERO       4'h0

`endif

// [logic/nand_timing_pkg.sv]
// Types shared by the flash access timer
package nand_timing_pkg;

    // Kind of a single asynchronous access
    typedef enum logic [1:0] {
        PH_CMD   = 2'h0,
        PH_ADDR  = 2'h1,
        PH_WDATA = 2'h2,
        PH_RDATA = 2'h3
    } phase_kind_t;

    // Access sequencer states
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_TURN   = 5'h02,
        ST_SETUP  = 5'h04,
        ST_STROBE = 5'h08,
        ST_HOLD   = 5'h10
    } seq_state_t;

    // Timing fields, each in cycles minus one
    typedef struct packed {
        logic [1:0] ta;
        logic [2:0] r_hold;
        logic [5:0] r_strobe;
        logic [3:0] r_setup;
        logic [2:0] w_hold;
        logic [5:0] w_strobe;
        logic [3:0] w_setup;
    } timing_cfg_t;

    // Flash-side output pins
    typedef struct packed {
        logic       cs_n;
        logic       we_n;
        logic       oe_n;
        logic       cle;
        logic       ale;
        logic       doe;
        logic [7:0] dout;
    } flash_pins_t;

endpackage

// [logic/phase_timer.sv]
// Down counter that times one access phase
`timescale 1ns/1ps
module phase_timer #(
    parameter int W = 6
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    // Status
    output logic              zero
);
    logic [W-1:0] cnt_r;   // Cycles left in phase

    // Load wins; otherwise count down to zero and stay there
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= load_val;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - W'(1);
        end
    end

    assign zero = (cnt_r == '0);
endmodule

// [logic/bus_sync.sv]
// Two-stage synchroniser for the flash data inputs
`timescale 1ns/1ps
module bus_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Pins and synchronised copy
    input  wire logic [W-1:0] async_in,
    output logic [W-1:0]      sync_out
);
    logic [W-1:0] meta_r;   // First stage, read only by second

    // Two flops, nothing looks at the first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// [test/nand_flash_model.sv]
// Behavioural model of an 8-bit asynchronous flash on one chip select
`timescale 1ns/1ps
module nand_flash_model
    import nand_timing_pkg::*;
#(
    parameter logic [7:0] RD_BYTE = 8'h5A
) (
    // Clock
    input  wire logic        pclk,
    // Pins from the access timer
    input  wire flash_pins_t pins,
    // Read data back to the timer
    output logic [7:0]       flash_din
);
    ////////////////////////////////////////////////////////////////////////////
    logic [9:0] log_q[$];       // Latched bytes as {cle, ale, byte}
    int         clash = 0;      // Cycles where both sides drove the data bus
    logic       we_n_r = 1'b1;  // Write strobe one cycle ago
    logic       tail_r = 1'b0;  // Output still turning off after a read
    wire        drive;          // Flash output on

    // Output on while selected with the read strobe low
    assign drive = !pins.cs_n && !pins.oe_n;
    // A released bus shows the inverse, so a stale sample cannot match
    assign flash_din = (drive || tail_r) ? RD_BYTE : ~RD_BYTE;

    ////////////////////////////////////////////////////////////////////////////
    // Latch on the rising write strobe; turn-off lasts one extra cycle
    always @(posedge pclk) begin
        we_n_r <= pins.we_n;
        tail_r <= drive;
        // Order of latched bytes is kept for the bench to judge
        if (we_n_r === 1'b0 && pins.we_n === 1'b1 && pins.cs_n === 1'b0) begin
            log_q.push_back({pins.cle, pins.ale, pins.dout});
        end
        // Timer driving while the flash output is still on is contention
        if (pins.doe === 1'b1 && (drive || tail_r)) begin
            clash <= clash + 1;
        end
    end
endmodule

// [test/async_nand_access_timing_tb.sv]
// Self-checking bench for the flash access timer
`timescale 1ns/1ps
`include "nand_timing_regs.svh"
module async_nand_access_timing_tb
    import nand_timing_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] FLASH_BYTE = 8'h5A;  // Byte the model returns
    // Write 2/3/1, read 3/4/2, turnaround 3 cycles; margin is chosen by us
    localparam timing_cfg_t CFG_A = '{ta: 2'h2, r_hold: 3'h1, r_strobe: 6'h03,
        r_setup: 4'h2, w_hold: 3'h0, w_strobe: 6'h02, w_setup: 4'h1};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        err;
    flash_pins_t pins;
    logic [7:0]  flash_din;
    int          mismatches = 0;
    int          compares = 0;

    nand_access_timing nand_access_timing_inst (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins(pins), .flash_din(flash_din));
    nand_flash_model #(.RD_BYTE(FLASH_BYTE)) nand_flash_model_inst (.pclk(pclk),
        .pins(pins), .flash_din(flash_din));

    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; starts after an edge so back-to-back calls never clash
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for pready; only the watchdog ends a stall
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Start one flash access of a given kind
    task automatic acc(input phase_kind_t k, input logic [7:0] b);
        apb(1'b1, `ACC_OFS, {22'h0, k, b});
    endtask

    // Count idle, setup, strobe and hold cycles of the access just started
    task automatic measure(input phase_kind_t k, input int ta, su, st, ho);
        int   c[4];
        int   bad;
        logic s;
        c = '{default: 0};
        bad = 0;
        // First sample is the cycle right after the accepting edge
        for (int i = 0; i < 300; i++) begin
            #1;
            s = (k == PH_RDATA) ? pins.oe_n : pins.we_n;
            if (pins.cs_n === 1'b0) begin
                // Latch enables, drive and the other strobe hold all access
                if ({pins.cle, pins.ale, pins.doe} !== {k == PH_CMD, k == PH_ADDR,
                    k != PH_RDATA} || ((k == PH_RDATA) ? pins.we_n : pins.oe_n) !== 1'b1)
                    bad++;
                if (s === 1'b0) c[2]++;
                else if (c[2] == 0) c[1]++;
                else c[3]++;
            end else if (c[1] > 0) break;
            else c[0]++;
            @(posedge pclk);
        end
        check("turnaround", ta, c[0]);
        check("setup", su, c[1]);
        check("strobe", st, c[2]);
        check("hold", ho, c[3]);
        check("pins during access", 0, bad);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Reset values, decode, refusals and separate read/write fields
    task automatic t_regs();
        apb(1'b0, `CFG_OFS, 32'h0);
        check("cfg reset", {4'h0, `CFG_RST}, rd);
        apb(1'b0, `STAT_OFS, 32'h0);
        check("stat reset", 32'h0, rd);
        apb(1'b1, `STAT_OFS, 32'hFFFFFFFF);
        apb(1'b0, `STAT_OFS, 32'h0);
        check("stat read only", 32'h0, rd);
        apb(1'b0, 12'h00C, 32'h0);
        check("unmapped error", 1, err);
        check("unmapped data", 32'h0, rd);
        apb(1'b1, `CFG_OFS, {4'hF, CFG_A});
        apb(1'b0, `CFG_OFS, 32'h0);
        check("cfg readback", {4'h0, CFG_A}, rd);
        check("cfg error", 0, err);
    endtask

    // Phase widths for both directions, busy flag, read byte, turnaround
    task automatic t_timing();
        acc(PH_CMD, 8'h70);
        measure(PH_CMD, 0, 2, 3, 1);
        acc(PH_ADDR, 8'h00);
        apb(1'b0, `STAT_OFS, 32'h0);
        check("busy", 1, rd[`STAT_BUSY_BIT]);
        acc(PH_RDATA, 8'h00);
        measure(PH_RDATA, 0, 3, 4, 2);
        apb(1'b0, `STAT_OFS, 32'h0);
        check("stat after read", {16'h0, FLASH_BYTE, 8'h02}, rd);
        acc(PH_WDATA, 8'hC3);
        measure(PH_WDATA, 3, 2, 3, 1);
        check("bus clash", 0, nand_flash_model_inst.clash);
        apb(1'b1, `CFG_OFS, 32'h0);
        acc(PH_CMD, 8'hFF);
        measure(PH_CMD, 0, 1, 1, 1);
    endtask

    // Whole program operation issued back to back, one access per phase
    task automatic t_flash_op();
        logic [9:0] exp[5];
        int         base;
        exp = '{10'h280, 10'h112, 10'h134, 10'h0A7, 10'h210};
        base = nand_flash_model_inst.log_q.size();
        apb(1'b1, `CFG_OFS, {4'h0, CFG_A});
        acc(PH_CMD, 8'h80);
        acc(PH_ADDR, 8'h12);
        acc(PH_ADDR, 8'h34);
        acc(PH_WDATA, 8'hA7);
        acc(PH_CMD, 8'h10);
        for (int i = 0; i < 50; i++) begin
            apb(1'b0, `STAT_OFS, 32'h0);
            if (rd[`STAT_BUSY_BIT] === 1'b0) break;
        end
        check("idle after op", 0, rd[`STAT_BUSY_BIT]);
        check("latched count", 5, nand_flash_model_inst.log_q.size() - base);
        for (int i = 0; i < 5; i++) begin
            check("latched byte", exp[i], nand_flash_model_inst.log_q[base + i]);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Clock, 50 ns period
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        #(50 * 20000);
        mismatches++;
        close_out();
    end

    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_timing();
        t_flash_op();
        close_out();
    end
endmodule
